// file: rtl/cps_consts.vh
// Constants of the channel protection supervisor
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH
`define CPS_NCH           8
`define CPS_FRAME_BITS    72
`define CPS_FRAME_MSB     71
`define CPS_BITCNT_LAST   7'h47
`define CPS_SCLK_HALF     3'h3
`define CPS_CLK_MHZ       125
`define CPS_MUTE_DLY_NS   20000
`define CPS_MUTE_DLY_CYC  ((`CPS_MUTE_DLY_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_HOLD_S        6
`define CPS_BLINK_FAST_MS 333
`define CPS_BLINK_SLOW_MS 2000
// Status byte of each channel in the input frame
`define CPS_SB_EN         0
`define CPS_SB_MUTED      1
`define CPS_SB_ILIM       2
`define CPS_SB_SHORT      3
`define CPS_SB_DC         4
`define CPS_SB_CLIP       5
// Switch byte sits above the eight status bytes
`define CPS_SW_LSB        64
`define CPS_SW_FANMASK    7
// Output frame layout
`define CPS_OF_MUTE_LSB   0
`define CPS_OF_EN_LSB     8
`define CPS_OF_LED_LSB    16
`define CPS_OF_ROW_LSB    23
// LED bits of one row
`define CPS_LED_CPL       0
`define CPS_LED_HF        1
`define CPS_LED_TEMP      2
`define CPS_LED_CLIP      3
`define CPS_LED_MUTE      4
// Analogue thresholds, 8-bit codes
`define CPS_LOWZ_LEVEL    8'h10
`define CPS_TEMP_TRIP     8'h33
`define CPS_TEMP_CLEAR    8'h40
`endif

// file: rtl/cps_row_mem.v
// Eight-row LED pattern store with registered read
`timescale 1ns/10ps
module cps_row_mem (
  input  wire       i_clk,
  input  wire       i_ce,
  input  wire       i_we,
  input  wire [2:0] i_waddr,
  input  wire [6:0] i_wdata,
  input  wire [2:0] i_raddr,
  output reg  [6:0] o_rdata
);
  reg [6:0] mem [0:7];

  // Contents carry no reset; rows are rewritten every eight cycles
  always @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we)
        mem[i_waddr] <= i_wdata;
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // cps_row_mem

// file: rtl/cps_shift_link.v
// Serial chain engine: one 72-bit frame in and out per start
`timescale 1ns/10ps
`include "cps_consts.vh"
module cps_shift_link (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_ce,
  input  wire        i_start,
  input  wire [71:0] i_tx,
  input  wire        i_miso,
  output reg         o_sclk,
  output reg         o_cs_n,
  output reg         o_mosi,
  output reg  [71:0] o_rx,
  output reg         o_done,
  output reg         o_busy
);
  reg [2:0]  div_q;
  reg [6:0]  cnt_q;
  reg [71:0] tx_q;
  reg [71:0] rx_q;

  // CS low samples the chain, each clock pulse moves it one stage
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sclk <= 1'b0;
      o_cs_n <= 1'b1;
      o_mosi <= 1'b0;
      o_rx   <= 72'h0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      div_q  <= 3'h0;
      cnt_q  <= 7'h0;
      tx_q   <= 72'h0;
      rx_q   <= 72'h0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_start) begin
          o_busy <= 1'b1;
          o_cs_n <= 1'b0;
          tx_q   <= i_tx;
          o_mosi <= i_tx[`CPS_FRAME_MSB];
          div_q  <= 3'h0;
          cnt_q  <= 7'h0;
        end
      end else if (div_q != `CPS_SCLK_HALF) begin
        div_q <= div_q + 3'h1;
      end else begin
        div_q <= 3'h0;
        if (!o_sclk) begin
          o_sclk <= 1'b1;
          rx_q   <= {rx_q[70:0], i_miso}; // Rising edge captures
        end else begin
          o_sclk <= 1'b0;
          if (cnt_q == `CPS_BITCNT_LAST) begin
            o_busy <= 1'b0;
            o_cs_n <= 1'b1;
            o_done <= 1'b1;
            o_rx   <= rx_q;
          end else begin
            cnt_q  <= cnt_q + 7'h1;
            tx_q   <= {tx_q[70:0], 1'b0};
            o_mosi <= tx_q[70];
          end
        end
      end
    end
  end
endmodule // cps_shift_link

// file: rtl/cps_supervisor.v
// Channel protection supervisor top level
// Behaviour
// - Mute first, drop enable after delay
// - Muted feedback bit is actual mute state
// - Current limit with low level: off 6s
// - Short circuit: mute 6s, CURRENT_PROTECT_LED lit
// - Enable low unmuted: HF protect 6s
// - DC fault: off, HF and CURRENT_PROTECT_LED lit
// - Hot: off with LED until cooled
// - Switch settings come from serial chain
// - Fan mask adds output level to fan
// - Input level and mode on direct pins
// - Remote valid only with power on
// - Panel output enable low until data valid
// - Shift seven LED bits plus row select
// - Advance row, wrap after last row
// - Comm LED fast without firmware, else slow
// - CS low samples, clocks shift chain
`timescale 1ns/10ps
`include "cps_consts.vh"
module cps_supervisor #(
  parameter [31:0] HOLD_CYC   = `CPS_HOLD_S * `CPS_CLK_MHZ * 1000000,
  parameter [31:0] BLINK_FAST = `CPS_BLINK_FAST_MS * `CPS_CLK_MHZ * 500,
  parameter [31:0] BLINK_SLOW = `CPS_BLINK_SLOW_MS * `CPS_CLK_MHZ * 500
) (
  input  wire       I_REF_CLK,
  input  wire       I_NRST,
  input  wire       I_CE,
  input  wire       I_MISO,
  input  wire       I_ADC_VALID,
  input  wire [7:0] I_ADC_DATA,
  input  wire [7:0] I_SPL_LEVEL,
  input  wire       I_FW_VALID,
  input  wire       I_POWER_SWITCH_SENSE,
  input  wire       I_REMOTE_SWITCH_SENSE,
  input  wire       I_GENERAL_INPUT_LEVEL,
  input  wire       I_GENERAL_INPUT_MODE,
  output reg        O_SCLK,
  output reg        O_CS_N,
  output reg        O_MOSI,
  output reg        O_PANEL_OE,
  output reg  [3:0] O_AMUX_SEL,
  output reg  [7:0] O_CH_MUTED,
  output reg  [7:0] O_CH_ENABLED,
  output reg  [7:0] O_SWITCHES,
  output reg  [7:0] O_FAN_VALUE,
  output reg        O_COMM_LED,
  output reg        O_POWER_ON,
  output reg        O_REMOTE_ON,
  output reg        O_GENERAL_INPUT_LEVEL,
  output reg        O_GENERAL_INPUT_MODE
);
  localparam [4:0] ST_RUN  = 5'h01;
  localparam [4:0] ST_PRE  = 5'h02;
  localparam [4:0] ST_HOLD = 5'h04;
  localparam [4:0] ST_TEMP = 5'h08;
  localparam [4:0] ST_DC   = 5'h10;

  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg  [71:0] stat_q;
  reg  [2:0]  row_q;
  reg  [2:0]  wr_idx_q;
  reg  [63:0] temp_all_q;
  reg  [63:0] level_all_q;
  reg  [31:0] blink_cnt_q;
  reg  [7:0]  fan_d;
  reg  [7:0]  tmin;
  integer     k;
  wire        lnk_sclk;
  wire        lnk_cs_n;
  wire        lnk_mosi;
  wire [71:0] lnk_rx;
  wire        lnk_done;
  wire        lnk_busy;
  wire [6:0]  row_led;
  wire [7:0]  mute_all;
  wire [7:0]  en_all;
  wire [55:0] led_all;
  wire [7:0]  row_sel_n;
  wire [71:0] tx_frame;
  wire [31:0] blink_lim;

  // Pin inputs pass two flops; only the second stage is read
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else if (I_CE) begin
      sync1_q <= {I_GENERAL_INPUT_MODE, I_GENERAL_INPUT_LEVEL,
                  I_REMOTE_SWITCH_SENSE, I_POWER_SWITCH_SENSE, I_MISO};
      sync2_q <= sync1_q;
    end
  end

  // Switch sense: remote only counts with power on
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_POWER_ON            <= 1'b0;
      O_REMOTE_ON           <= 1'b0;
      O_GENERAL_INPUT_LEVEL <= 1'b0;
      O_GENERAL_INPUT_MODE  <= 1'b0;
    end else if (I_CE) begin
      O_POWER_ON            <= sync2_q[1];
      O_REMOTE_ON           <= sync2_q[1] & sync2_q[2];
      O_GENERAL_INPUT_LEVEL <= sync2_q[3]; // Direct pins, live in standby
      O_GENERAL_INPUT_MODE  <= sync2_q[4];
    end
  end

  // Row selector: only the scanned row line is low
  assign row_sel_n = ~(8'h01 << row_q);
  assign tx_frame  = {41'h0, row_sel_n, row_led, en_all, mute_all};

  // Frames run back to back; each carries one LED row
  cps_shift_link u_link (
    .i_clk   (I_REF_CLK),
    .i_nrst  (I_NRST),
    .i_ce    (I_CE),
    .i_start (1'b1),
    .i_tx    (tx_frame),
    .i_miso  (sync2_q[0]),
    .o_sclk  (lnk_sclk),
    .o_cs_n  (lnk_cs_n),
    .o_mosi  (lnk_mosi),
    .o_rx    (lnk_rx),
    .o_done  (lnk_done),
    .o_busy  (lnk_busy)
  );

  // Link pins re-registered so top outputs come from flops
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_SCLK <= 1'b0;
      O_CS_N <= 1'b1;
      O_MOSI <= 1'b0;
    end else if (I_CE) begin
      O_SCLK <= lnk_sclk;
      O_CS_N <= lnk_cs_n;
      O_MOSI <= lnk_mosi;
    end
  end

  // Frame results, row scan and panel enable
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      stat_q     <= 72'h0;
      row_q      <= 3'h0;
      O_PANEL_OE <= 1'b0;
      O_SWITCHES <= 8'h00;
    end else if (I_CE && lnk_done) begin
      stat_q     <= lnk_rx;
      O_SWITCHES <= lnk_rx[`CPS_SW_LSB +: 8]; // Settings via chain
      row_q      <= row_q + 3'h1; // Wraps from last row to first
      O_PANEL_OE <= 1'b1; // Released once a valid row is shifted
    end
  end

  // Refresh one LED row per cycle from the channel state
  always @(posedge I_REF_CLK) begin
    if (!I_NRST)
      wr_idx_q <= 3'h0;
    else if (I_CE)
      wr_idx_q <= wr_idx_q + 3'h1;
  end

  cps_row_mem u_rows (
    .i_clk   (I_REF_CLK),
    .i_ce    (I_CE),
    .i_we    (1'b1),
    .i_waddr (wr_idx_q),
    .i_wdata (led_all[wr_idx_q*7 +: 7]),
    .i_raddr (row_q),
    .o_rdata (row_led)
  );

  // Analogue scan: level and temperature for each channel in turn
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_AMUX_SEL  <= 4'h0;
      temp_all_q  <= {8{8'hff}};
      level_all_q <= {8{8'hff}};
    end else if (I_CE && I_ADC_VALID) begin
      if (O_AMUX_SEL[3])
        temp_all_q[O_AMUX_SEL[2:0]*8 +: 8] <= I_ADC_DATA;
      else
        level_all_q[O_AMUX_SEL[2:0]*8 +: 8] <= I_ADC_DATA;
      O_AMUX_SEL <= O_AMUX_SEL + 4'h1;
    end
  end

  // Fan demand follows the hottest module; lower code means hotter
  always @* begin
    tmin = 8'hff;
    for (k = 0; k < `CPS_NCH; k = k + 1) begin
      if (temp_all_q[k*8 +: 8] < tmin)
        tmin = temp_all_q[k*8 +: 8];
    end
    fan_d = ~tmin;
    if (O_SWITCHES[`CPS_SW_FANMASK] && I_SPL_LEVEL > fan_d)
      fan_d = I_SPL_LEVEL; // Output level joins the fan value
  end

  always @(posedge I_REF_CLK) begin
    if (!I_NRST)
      O_FAN_VALUE <= 8'h00;
    else if (I_CE)
      O_FAN_VALUE <= fan_d;
  end

  // Comm LED blink rate shows whether firmware is valid
  assign blink_lim = I_FW_VALID ? BLINK_SLOW : BLINK_FAST;
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      blink_cnt_q <= 32'h0;
      O_COMM_LED  <= 1'b0;
    end else if (I_CE) begin
      if (blink_cnt_q >= blink_lim - 32'h1) begin
        blink_cnt_q <= 32'h0;
        O_COMM_LED  <= ~O_COMM_LED;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h1;
      end
    end
  end

  // Per-channel protection state machine
  genvar g;
  generate
    for (g = 0; g < `CPS_NCH; g = g + 1) begin : g_ch
      reg  [4:0]  st_q;
      reg  [31:0] tmr_q;
      reg  [1:0]  dest_q;
      reg         off_q;
      reg         cpl_q;
      reg         hf_q;
      wire [7:0]  sb      = stat_q[g*8 +: 8];
      wire [7:0]  temp    = temp_all_q[g*8 +: 8];
      wire        muted   = sb[`CPS_SB_MUTED]; // Actual mute state
      wire        hot     = temp < `CPS_TEMP_TRIP;
      wire        low_z   = sb[`CPS_SB_ILIM] &&
                            level_all_q[g*8 +: 8] < `CPS_LOWZ_LEVEL;
      wire        hf_evt  = !sb[`CPS_SB_EN] && !muted && !sb[`CPS_SB_SHORT];

      assign mute_all[g] = (st_q != ST_RUN);
      // Enable stays high while muting settles
      assign en_all[g]   = (st_q == ST_RUN) || (st_q == ST_PRE) ||
                           ((st_q == ST_HOLD) && !off_q);
      assign led_all[g*7 +: 7] = {2'b00, muted, sb[`CPS_SB_CLIP],
                                  (st_q == ST_TEMP), hf_q, cpl_q};

      always @(posedge I_REF_CLK) begin
        if (!I_NRST) begin
          st_q   <= ST_RUN;
          tmr_q  <= 32'h0;
          dest_q <= 2'h0;
          off_q  <= 1'b0;
          cpl_q  <= 1'b0;
          hf_q   <= 1'b0;
        end else if (I_CE) begin
          case (st_q)
            ST_RUN: begin
              tmr_q <= 32'h0;
              cpl_q <= 1'b0;
              hf_q  <= 1'b0;
              // Faults are checked every cycle, also just after a hold
              if (sb[`CPS_SB_DC]) begin
                st_q   <= ST_PRE; // Shut off, show fault
                dest_q <= 2'h2;
                cpl_q  <= 1'b1;
                hf_q   <= 1'b1;
              end else if (sb[`CPS_SB_SHORT]) begin
                st_q  <= ST_HOLD; // Mute only, CURRENT_PROTECT_LED steady
                off_q <= 1'b0;
                cpl_q <= 1'b1;
              end else if (hot) begin
                st_q   <= ST_PRE;
                dest_q <= 2'h1;
              end else if (low_z) begin
                st_q   <= ST_PRE;
                dest_q <= 2'h0;
                cpl_q  <= 1'b1;
              end else if (hf_evt) begin
                st_q  <= ST_HOLD; // Held muted with HF LED
                off_q <= 1'b0;
                hf_q  <= 1'b1;
              end
            end
            ST_PRE: begin
              // Enable drops only after delay and confirmed mute
              if (tmr_q >= `CPS_MUTE_DLY_CYC - 1 && muted) begin
                tmr_q <= 32'h0;
                off_q <= 1'b1;
                if (dest_q == 2'h2)
                  st_q <= ST_DC;
                else if (dest_q == 2'h1)
                  st_q <= ST_TEMP;
                else
                  st_q <= ST_HOLD;
              end else begin
                tmr_q <= tmr_q + 32'h1;
              end
            end
            ST_HOLD: begin
              if (tmr_q >= HOLD_CYC - 32'h1) begin
                st_q  <= ST_RUN; // Six seconds over
                off_q <= 1'b0;
              end else begin
                tmr_q <= tmr_q + 32'h1;
              end
            end
            ST_TEMP: begin
              if (temp >= `CPS_TEMP_CLEAR) begin
                st_q  <= ST_RUN; // Cooled down
                off_q <= 1'b0;
              end
            end
            ST_DC: begin
              st_q <= ST_DC; // Latched until reset
            end
            default: begin
              st_q <= ST_RUN;
            end
          endcase
        end
      end
    end
  endgenerate

  // Channel status outputs
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_CH_MUTED   <= 8'h00;
      O_CH_ENABLED <= 8'h00;
    end else if (I_CE) begin
      O_CH_MUTED   <= mute_all;
      O_CH_ENABLED <= en_all;
    end
  end
endmodule // cps_supervisor

// file: test/cps_chain_model.sv
// Chain, amplifier module and panel model
`timescale 1ns/10ps
module cps_chain_model (
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire        i_mosi,
  input  wire [71:0] i_faults,
  output reg         o_miso,
  output reg  [71:0] o_out_frame,
  output reg  [31:0] o_frames
);
  reg [71:0] in_sh = 72'h0;
  reg [71:0] out_sh = 72'h0;
  initial o_out_frame = 72'h0;
  initial o_frames = 32'h0;
  initial o_miso = 1'b0;
  // Select low latches flags; enable sense and mute confirm echo last commands
  always @(negedge i_cs_n) begin
    in_sh = i_faults;
    for (int g = 0; g < 8; g++) begin
      in_sh[8*g] = o_out_frame[8+g];
      in_sh[8*g+1] = o_out_frame[g];
    end
    o_miso = in_sh[71];
  end
  // One stage per clock, most significant bit first
  always @(posedge i_sclk) if (!i_cs_n) out_sh = {out_sh[70:0], i_mosi};
  always @(negedge i_sclk) begin
    if (!i_cs_n) begin
      in_sh = {in_sh[70:0], 1'b0};
      o_miso = in_sh[71];
    end
  end
  // Released line flips so a stale bit never passes as valid
  always @(posedge i_cs_n) begin
    o_out_frame = out_sh;
    o_frames = o_frames + 32'h1;
    o_miso = ~o_miso;
  end
endmodule // cps_chain_model

// file: test/cps_supervisor_props.sv
// Port assertions for the protection supervisor
`timescale 1ns/10ps
module cps_supervisor_props (
  input wire       I_REF_CLK,
  input wire       I_NRST,
  input wire       I_CE,
  input wire       I_ADC_VALID,
  input wire       O_SCLK,
  input wire       O_CS_N,
  input wire       O_MOSI,
  input wire       O_PANEL_OE,
  input wire [3:0] O_AMUX_SEL,
  input wire [7:0] O_CH_MUTED,
  input wire [7:0] O_CH_ENABLED,
  input wire       O_POWER_ON,
  input wire       O_REMOTE_ON
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  reg in_frame_q;
  reg frame_seen_q;
  // Panel may only light once a whole frame has gone out
  always @(posedge I_REF_CLK) begin
    in_frame_q   <= I_NRST & (in_frame_q | !O_CS_N);
    frame_seen_q <= I_NRST & (frame_seen_q | (in_frame_q & O_CS_N));
  end
  a_mute_first: assert property (
    (($past(O_CH_ENABLED) & ~O_CH_ENABLED & ~$past(O_CH_MUTED, 8)) == 8'h00))
    else $error("enable dropped without mute");
  a_frame_len: assert property ($fell(O_CS_N) |-> !O_CS_N [*8])
    else $error("frame too short");
  a_frame_gap: assert property ($rose(O_CS_N) |=> !O_CS_N)
    else $error("idle gap not one cycle");
  a_clk_idle: assert property (O_CS_N |-> !O_SCLK)
    else $error("clock outside frame");
  a_clk_high: assert property ($rose(O_SCLK) |-> O_SCLK [*4] ##1 !O_SCLK)
    else $error("clock high phase wrong");
  a_data_hold: assert property (O_SCLK |-> $stable(O_MOSI))
    else $error("data moved while clock high");
  a_remote_gate: assert property (O_REMOTE_ON |-> O_POWER_ON)
    else $error("remote without power");
  a_panel_dark: assert property (O_PANEL_OE |-> (frame_seen_q || O_CS_N))
    else $error("panel enabled before data");
  a_mux_step: assert property (
    I_ADC_VALID && I_CE |=> O_AMUX_SEL == $past(O_AMUX_SEL) + 4'h1)
    else $error("mux did not advance");
  cover property (|($past(O_CH_ENABLED) & ~O_CH_ENABLED));
  cover property ($rose(O_PANEL_OE));
  cover property ($rose(O_REMOTE_ON));
endmodule // cps_supervisor_props
bind cps_supervisor cps_supervisor_props u_props (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST),
  .I_CE(I_CE), .I_ADC_VALID(I_ADC_VALID), .O_SCLK(O_SCLK), .O_CS_N(O_CS_N), .O_MOSI(O_MOSI),
  .O_PANEL_OE(O_PANEL_OE), .O_AMUX_SEL(O_AMUX_SEL), .O_CH_MUTED(O_CH_MUTED),
  .O_CH_ENABLED(O_CH_ENABLED), .O_POWER_ON(O_POWER_ON), .O_REMOTE_ON(O_REMOTE_ON));

// file: test/tb_channel_protection_supervisor.sv
// Self-checking bench for the protection supervisor
`timescale 1ns/10ps
module tb_channel_protection_supervisor;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        adc_v = 1'b0;
  logic [7:0]  adc_d = 8'h00;
  logic [7:0]  spl = 8'h00;
  logic        fw = 1'b0;
  logic [3:0]  sw = 4'h0;
  logic [71:0] flt = 72'h0;
  logic [7:0]  temp [8];
  logic [7:0]  lvl [8];
  logic [7:0]  rsel;
  logic [6:0]  led;
  int          fail_count = 0;
  int          num_checks = 0;
  int          gap, nrow, prow;
  wire         miso, sclk, cs_n, mosi, oe, comm, pwr, rem, gl, gm;
  wire [3:0]   amux;
  wire [7:0]   muted, enab, swo, fan;
  wire [71:0]  ofr;
  wire [31:0]  frames;
  always #4 clk = ~clk;
  cps_supervisor #(.HOLD_CYC(32'h7d0), .BLINK_FAST(32'h32), .BLINK_SLOW(32'h12c)) u_dut (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_MISO(miso), .I_ADC_VALID(adc_v),
    .I_ADC_DATA(adc_d), .I_SPL_LEVEL(spl), .I_FW_VALID(fw), .I_POWER_SWITCH_SENSE(sw[3]),
    .I_REMOTE_SWITCH_SENSE(sw[2]), .I_GENERAL_INPUT_LEVEL(sw[1]), .I_GENERAL_INPUT_MODE(sw[0]),
    .O_SCLK(sclk), .O_CS_N(cs_n), .O_MOSI(mosi), .O_PANEL_OE(oe), .O_AMUX_SEL(amux),
    .O_CH_MUTED(muted), .O_CH_ENABLED(enab), .O_SWITCHES(swo), .O_FAN_VALUE(fan),
    .O_COMM_LED(comm), .O_POWER_ON(pwr), .O_REMOTE_ON(rem), .O_GENERAL_INPUT_LEVEL(gl),
    .O_GENERAL_INPUT_MODE(gm));
  cps_chain_model u_chain (.i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_faults(flt),
    .o_miso(miso), .o_out_frame(ofr), .o_frames(frames));
  // Mux answers for the selected input; the strobe is random to vary spacing
  always @(posedge clk) begin
    #1;
    adc_v = $urandom % 2;
    adc_d = amux[3] ? temp[amux[2:0]] : lvl[amux[2:0]];
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("BAD %0t wait timed out", $time);
    test_done;
  endtask
  task automatic wait_frames(input int n);
    int f0;
    int t;
    f0 = frames;
    t = 0;
    while (frames < f0 + n) begin
      @(posedge clk);
      t++;
      if (t > 600 * n) hang;
    end
    // State follows the frame by a couple of register stages
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Panel pattern of one channel, taken from the frame that selects its row
  task automatic get_led(input int ch, output logic [6:0] l);
    l = 7'h7f;
    for (int k = 0; k < 9 && l === 7'h7f; k++) begin
      wait_frames(1);
      if (ofr[30:23] === ~(8'h01 << ch)) l = ofr[22:16];
    end
    // Top LED bits are always zero, so the marker means the row never came
    if (l === 7'h7f) hang;
  endtask
  // Syncs to one toggle, then counts cycles to the next
  task automatic blink_gap(output int n);
    logic c;
    for (int k = 0; k < 2; k++) begin
      c = comm;
      n = 0;
      while (comm === c) begin
        @(posedge clk);
        #1;
        n++;
        if (n > 700) hang;
      end
    end
  endtask
  initial begin
    void'($urandom(93));
    for (int c = 0; c < 8; c++) begin
      temp[c] = 8'hff;
      lvl[c] = 8'hff;
    end
    repeat (16) @(posedge clk);
    #1;
    check(oe, 1'b0);
    check(cs_n, 1'b1);
    nrst = 1'b1;
    // Empty first frame reads as a module trip on every channel
    wait_frames(2);
    check(oe, 1'b1);
    check({muted, enab}, 16'hffff);
    get_led(2, led);
    check(led[1], 1'b1);
    wait_frames(6);
    check(muted, 8'h00);
    // Row selector walks one step per frame and wraps
    for (int k = 0; k < 9; k++) begin
      wait_frames(1);
      nrow = 0;
      for (int b = 0; b < 8; b++) if (ofr[23+b] === 1'b0) nrow = b;
      rsel = ~(8'h01 << nrow);
      check(ofr[30:23], rsel);
      if (k > 0) check(nrow, (prow + 1) % 8);
      prow = nrow;
    end
    flt[71:64] = $urandom;
    wait_frames(3);
    check(swo, flt[71:64]);
    // Short circuit held past the hold, then cleared
    flt[11] = 1'b1;
    wait_frames(2);
    check({muted[1], enab[1]}, 2'b11);
    get_led(1, led);
    check(led[0], 1'b1);
    wait_frames(5);
    check(muted[1], 1'b1);
    flt[11] = 1'b0;
    wait_frames(7);
    check(muted[1], 1'b0);
    // Output fault: mute first, enable later, latched until reset
    flt[20] = 1'b1;
    wait_frames(2);
    check({muted[2], enab[2]}, 2'b11);
    wait_frames(6);
    check({muted[2], enab[2]}, 2'b10);
    get_led(2, led);
    check(led[1:0], 2'b11);
    flt[20] = 1'b0;
    wait_frames(5);
    check(enab[2], 1'b0);
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(oe, 1'b0);
    nrst = 1'b1;
    wait_frames(8);
    check(muted, 8'h00);
    // Overheat with hysteresis between trip and clear codes
    temp[3] = 8'h32;
    wait_frames(8);
    check({muted[3], enab[3]}, 2'b10);
    get_led(3, led);
    check(led[2], 1'b1);
    temp[3] = 8'h3f;
    wait_frames(4);
    check(enab[3], 1'b0);
    temp[3] = 8'h40;
    wait_frames(6);
    check({muted[3], enab[3]}, 2'b01);
    // Current limit alone is harmless; with a low level it trips
    flt[34] = 1'b1;
    wait_frames(3);
    check(muted[4], 1'b0);
    lvl[4] = 8'h0f;
    wait_frames(2);
    check(muted[4], 1'b1);
    get_led(4, led);
    check(led[0], 1'b1);
    flt[34] = 1'b0;
    lvl[4] = 8'hff;
    wait_frames(8);
    check(muted[4], 1'b0);
    // Fan follows the hottest module (code 8'h40); the mask lets output level raise it
    for (int k = 0; k < 2; k++) begin
      flt[71] = (k == 1);
      spl = 8'hc0 | 8'($urandom);
      wait_frames(2);
      check(fan, k ? spl : 8'hbf);
    end
    for (int k = 0; k < 8; k++) begin
      sw = {2'(k), 2'($urandom)};
      repeat (5) @(posedge clk);
      #1;
      check({pwr, rem, gl, gm}, {sw[3], sw[3] & sw[2], sw[1:0]});
    end
    blink_gap(gap);
    check(gap, 50);
    fw = 1'b1;
    blink_gap(gap);
    check(gap, 300);
    test_done;
  end
endmodule // tb_channel_protection_supervisor
